// ==== logic/pmbs_status_registers.sv ====
`timescale 1ns/1ps
// What this block does
// - input status at 7Ch, low nibble zero
// - input overvoltage fault sets bit 7
// - input overvoltage warning sets bit 6
// - input undervoltage warning sets bit 5
// - input undervoltage fault sets bit 4
// - temperature status at 7Dh, low nibble zero
// - over-temperature fault sets bit 7
// - over-temperature warning sets bit 6
// - under-temperature warning sets bit 5
// - under-temperature fault sets bit 4
// - comms status at 7Eh, bits 4:2,0 zero
// - unsupported command code sets bit 7
// - invalid data sets bit 6
// - bad packet error code sets bit 5
// - write to read-only sets bit 1
// - vendor status at 80h, bits 7,2 zero
// - interconnect bus error sets bit 6
// - monitor ten percent under sets bit 5
// - monitor ten percent over sets bit 4
// - lost external clock sync sets bit 3
// - monitor below undervoltage limit sets bit 1
// - monitor above overvoltage limit sets bit 0
// - summary bit 9 on any status
// - summary bit 2 on temperature status
// - summary bit 1 on comms status
// - summary bit 13 on input status
module pmbs_status_registers #(
  parameter logic [6:0] DEV_ADDR = pmbs_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic INPUT_OV_FAULT,
  input wire logic INPUT_OV_WARN,
  input wire logic INPUT_UV_WARN,
  input wire logic INPUT_UV_FAULT,
  input wire logic TEMP_OT_FAULT,
  input wire logic TEMP_OT_WARN,
  input wire logic TEMP_UT_WARN,
  input wire logic TEMP_UT_FAULT,
  input wire logic INTERCONNECT_ERR,
  input wire logic EXT_SYNC_LOST,
  input wire logic [11:0] MONITOR_PIN_VOLTAGE,
  input wire logic [11:0] MONITOR_UV_LIMIT,
  input wire logic [11:0] MONITOR_OV_LIMIT,
  input wire logic OUTPUT_STATUS_ANY,
  input wire logic CLEAR_FAULTS,
  output logic [15:0] SUMMARY_WORD
);
  pmbs_stat_if sif ();

  logic scl_rise;
  logic scl_fall;
  logic sda_now;
  logic start_det;
  logic stop_det;
  logic [7:0] input_set;
  logic [7:0] temp_set;

  pmbs_pkg::pmbs_state_t state;
  pmbs_pkg::pmbs_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic rw;
  logic next_rw;
  logic in_txn;
  logic next_in_txn;
  logic got_cmd;
  logic next_got_cmd;
  logic [1:0] wr_cnt;
  logic [1:0] next_wr_cnt;
  logic [1:0] rd_idx;
  logic [1:0] next_rd_idx;
  logic host_ack;
  logic next_host_ack;
  logic [7:0] crc;
  logic [7:0] next_crc;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic oe_n;
  logic next_oe_n;
  logic ev_bad_cmd;
  logic ev_bad_data;
  logic ev_pec;
  logic ev_other;
  logic next_ev_bad_cmd;
  logic next_ev_bad_data;
  logic next_ev_pec;
  logic next_ev_other;
  logic [7:0] tx_byte;

  pmbs_pin_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .scl(SCL),
    .sda(SDA_IN),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .sda_now(sda_now),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  always_comb begin
    input_set = 8'h00;
    input_set[pmbs_pkg::IN_OV_FAULT_BIT] = INPUT_OV_FAULT;
    input_set[pmbs_pkg::IN_OV_WARN_BIT] = INPUT_OV_WARN;
    input_set[pmbs_pkg::IN_UV_WARN_BIT] = INPUT_UV_WARN;
    input_set[pmbs_pkg::IN_UV_FAULT_BIT] = INPUT_UV_FAULT;
    temp_set = 8'h00;
    temp_set[pmbs_pkg::TMP_OT_FAULT_BIT] = TEMP_OT_FAULT;
    temp_set[pmbs_pkg::TMP_OT_WARN_BIT] = TEMP_OT_WARN;
    temp_set[pmbs_pkg::TMP_UT_WARN_BIT] = TEMP_UT_WARN;
    temp_set[pmbs_pkg::TMP_UT_FAULT_BIT] = TEMP_UT_FAULT;
  end

  pmbs_status_bank u_bank (
    .clk(REF_CLK),
    .rst(RST),
    .sif(sif.bank),
    .input_set(input_set),
    .temp_set(temp_set),
    .bus_err(INTERCONNECT_ERR),
    .sync_lost(EXT_SYNC_LOST),
    .mon_v(MONITOR_PIN_VOLTAGE),
    .uv_lim(MONITOR_UV_LIMIT),
    .ov_lim(MONITOR_OV_LIMIT),
    .out_any(OUTPUT_STATUS_ANY),
    .clear(CLEAR_FAULTS),
    .summary(SUMMARY_WORD)
  );

  // data byte, then its packet error code, then idle ones
  always_comb begin
    case (rd_idx)
      pmbs_pkg::RD_DATA: tx_byte = sif.rdata;
      pmbs_pkg::RD_PEC: tx_byte = crc;
      default: tx_byte = pmbs_pkg::IDLE_BYTE;
    endcase
  end

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_rw = rw;
    next_in_txn = in_txn;
    next_got_cmd = got_cmd;
    next_wr_cnt = wr_cnt;
    next_rd_idx = rd_idx;
    next_host_ack = host_ack;
    next_crc = crc;
    next_cmd = cmd;
    next_oe_n = oe_n;
    next_ev_bad_cmd = 1'b0;
    next_ev_bad_data = 1'b0;
    next_ev_pec = 1'b0;
    next_ev_other = 1'b0;
    if (start_det) begin
      if (state != pmbs_pkg::ST_IDLE && !rw && wr_cnt != 2'h0) begin
        next_ev_bad_data = 1'b1;
      end
      // repeated start keeps the running code for the read's check byte
      if (!in_txn) begin
        next_crc = pmbs_pkg::PEC_INIT;
      end
      next_in_txn = 1'b1;
      next_state = pmbs_pkg::ST_ADDR;
      next_bit_cnt = 4'h0;
      next_oe_n = 1'b1;
      next_wr_cnt = 2'h0;
      next_got_cmd = 1'b0;
      next_rd_idx = pmbs_pkg::RD_DATA;
    end else if (stop_det) begin
      if (in_txn && !rw && got_cmd) begin
        if (pmbs_pkg::cmd_supported(cmd) && wr_cnt != 2'h0) begin
          next_ev_other = 1'b1;
        end
        if (wr_cnt >= 2'h2 && crc != 8'h00) begin
          next_ev_pec = 1'b1;
        end
      end
      next_state = pmbs_pkg::ST_IDLE;
      next_in_txn = 1'b0;
      next_oe_n = 1'b1;
      next_got_cmd = 1'b0;
      next_wr_cnt = 2'h0;
    end else begin
      case (state)
        pmbs_pkg::ST_ADDR, pmbs_pkg::ST_RX: begin
          if (scl_rise && bit_cnt != pmbs_pkg::BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_now};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
          end else if (scl_fall && bit_cnt == pmbs_pkg::BYTE_BITS) begin
            next_bit_cnt = 4'h0;
            if (state == pmbs_pkg::ST_ADDR) begin
              if (shreg[7:1] == DEV_ADDR) begin
                next_rw = shreg[0];
                next_crc = pmbs_pkg::crc8(crc, shreg);
                next_oe_n = 1'b0;
                next_state = pmbs_pkg::ST_ACK_ADDR;
              end else begin
                next_state = pmbs_pkg::ST_WAIT;
              end
            end else begin
              next_crc = pmbs_pkg::crc8(crc, shreg);
              next_oe_n = 1'b0;
              next_state = pmbs_pkg::ST_ACK_RX;
              if (!got_cmd) begin
                next_got_cmd = 1'b1;
                next_cmd = shreg;
                next_ev_bad_cmd = !pmbs_pkg::cmd_supported(shreg);
              end else if (wr_cnt != 2'h3) begin
                next_wr_cnt = 2'(wr_cnt + 2'h1);
              end
            end
          end
        end
        pmbs_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw) begin
              next_shreg = tx_byte;
              next_oe_n = tx_byte[7];
              if (rd_idx == pmbs_pkg::RD_DATA) begin
                next_crc = pmbs_pkg::crc8(crc, tx_byte);
              end
              next_state = pmbs_pkg::ST_TX;
            end else begin
              next_oe_n = 1'b1;
              next_state = pmbs_pkg::ST_RX;
            end
          end
        end
        pmbs_pkg::ST_ACK_RX: begin
          if (scl_fall) begin
            next_oe_n = 1'b1;
            next_state = pmbs_pkg::ST_RX;
          end
        end
        pmbs_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == pmbs_pkg::LAST_BIT) begin
              next_bit_cnt = 4'h0;
              next_oe_n = 1'b1;
              next_state = pmbs_pkg::ST_ACK_TX;
              if (rd_idx != 2'h3) begin
                next_rd_idx = 2'(rd_idx + 2'h1);
              end
            end else begin
              next_bit_cnt = 4'(bit_cnt + 4'h1);
              next_shreg = {shreg[6:0], 1'b1};
              next_oe_n = shreg[6];
            end
          end
        end
        pmbs_pkg::ST_ACK_TX: begin
          if (scl_rise) begin
            next_host_ack = !sda_now;
          end else if (scl_fall) begin
            if (host_ack) begin
              next_shreg = tx_byte;
              next_oe_n = tx_byte[7];
              next_state = pmbs_pkg::ST_TX;
            end else begin
              next_state = pmbs_pkg::ST_WAIT;
            end
          end
        end
        pmbs_pkg::ST_WAIT: begin
          next_oe_n = 1'b1;
        end
        default: begin
          next_oe_n = 1'b1;
          next_state = pmbs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state <= pmbs_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      in_txn <= 1'b0;
      got_cmd <= 1'b0;
      wr_cnt <= 2'h0;
      rd_idx <= pmbs_pkg::RD_DATA;
      host_ack <= 1'b0;
      crc <= pmbs_pkg::PEC_INIT;
      cmd <= pmbs_pkg::IDLE_BYTE;
      oe_n <= 1'b1;
      ev_bad_cmd <= 1'b0;
      ev_bad_data <= 1'b0;
      ev_pec <= 1'b0;
      ev_other <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      rw <= next_rw;
      in_txn <= next_in_txn;
      got_cmd <= next_got_cmd;
      wr_cnt <= next_wr_cnt;
      rd_idx <= next_rd_idx;
      host_ack <= next_host_ack;
      crc <= next_crc;
      cmd <= next_cmd;
      oe_n <= next_oe_n;
      ev_bad_cmd <= next_ev_bad_cmd;
      ev_bad_data <= next_ev_bad_data;
      ev_pec <= next_ev_pec;
      ev_other <= next_ev_other;
    end
  end

  assign sif.cmd = cmd;
  assign sif.ev_bad_cmd = ev_bad_cmd;
  assign sif.ev_bad_data = ev_bad_data;
  assign sif.ev_pec = ev_pec;
  assign sif.ev_other = ev_other;
  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = oe_n;
endmodule : pmbs_status_registers

// ==== common/pmbs_pkg.sv ====
package pmbs_pkg;
  // command codes of the four status registers
  localparam logic [7:0] CMD_INPUT = 8'h7C;
  localparam logic [7:0] CMD_TEMP = 8'h7D;
  localparam logic [7:0] CMD_CML = 8'h7E;
  localparam logic [7:0] CMD_VENDOR = 8'h80;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // implemented bits; all others read zero
  localparam logic [7:0] INPUT_MASK = 8'hF0;
  localparam logic [7:0] TEMP_MASK = 8'hF0;
  localparam logic [7:0] CML_MASK = 8'hE2;
  localparam logic [7:0] VENDOR_MASK = 8'h7B;
  localparam int IN_OV_FAULT_BIT = 7;
  localparam int IN_OV_WARN_BIT = 6;
  localparam int IN_UV_WARN_BIT = 5;
  localparam int IN_UV_FAULT_BIT = 4;
  localparam int TMP_OT_FAULT_BIT = 7;
  localparam int TMP_OT_WARN_BIT = 6;
  localparam int TMP_UT_WARN_BIT = 5;
  localparam int TMP_UT_FAULT_BIT = 4;
  localparam int CML_BAD_CMD_BIT = 7;
  localparam int CML_BAD_DATA_BIT = 6;
  localparam int CML_PEC_BIT = 5;
  localparam int CML_OTHER_BIT = 1;
  localparam int VEN_BUS_BIT = 6;
  localparam int VEN_UV_WARN_BIT = 5;
  localparam int VEN_OV_WARN_BIT = 4;
  localparam int VEN_SYNC_BIT = 3;
  localparam int VEN_UV_FAULT_BIT = 1;
  localparam int VEN_OV_FAULT_BIT = 0;
  localparam int SUM_INPUT_BIT = 13;
  localparam int SUM_VENDOR_BIT = 12;
  localparam int SUM_OTHER_BIT = 9;
  localparam int SUM_TEMP_BIT = 2;
  localparam int SUM_CML_BIT = 1;
  // 10 % margins as ratios over ten
  localparam logic [15:0] MON_SCALE = 16'h000A;
  localparam logic [15:0] MON_UV_WARN_SCALE = 16'h0009;
  localparam logic [15:0] MON_OV_WARN_SCALE = 16'h000B;
  // value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_INIT = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] RD_DATA = 2'h0;
  localparam logic [1:0] RD_PEC = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_RX = 3'b011,
    ST_ACK_RX = 3'b100,
    ST_TX = 3'b101,
    ST_ACK_TX = 3'b110,
    ST_WAIT = 3'b111
  } pmbs_state_t;

  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ PEC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  function automatic logic cmd_supported(input logic [7:0] cmd);
    return (cmd == CMD_INPUT) || (cmd == CMD_TEMP) || (cmd == CMD_CML) || (cmd == CMD_VENDOR);
  endfunction : cmd_supported
endpackage : pmbs_pkg

// ==== common/pmbs_stat_if.sv ====
`timescale 1ns/1ps
interface pmbs_stat_if;
  logic [7:0] cmd;
  logic [7:0] rdata;
  logic ev_bad_cmd;
  logic ev_bad_data;
  logic ev_pec;
  logic ev_other;
  modport engine (output cmd, output ev_bad_cmd, output ev_bad_data, output ev_pec,
    output ev_other, input rdata);
  modport bank (input cmd, input ev_bad_cmd, input ev_bad_data, input ev_pec,
    input ev_other, output rdata);
endinterface : pmbs_stat_if

// ==== logic/pmbs_pin_sync.sv ====
`timescale 1ns/1ps
module pmbs_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic sda_now,
  output logic start_det,
  output logic stop_det
);
  logic [1:0] meta;
  logic [1:0] stable;
  logic [1:0] prev;
  logic [1:0] next_meta;
  logic [1:0] next_stable;
  logic [1:0] next_prev;

  // edges look only at second and third stages
  always_comb begin
    next_meta = {scl, sda};
    next_stable = meta;
    next_prev = stable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 2'h3;
      stable <= 2'h3;
      prev <= 2'h3;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  assign scl_rise = stable[1] && !prev[1];
  assign scl_fall = !stable[1] && prev[1];
  assign sda_now = stable[0];
  // sda moving while scl stays high frames a transaction
  assign start_det = stable[1] && prev[1] && !stable[0] && prev[0];
  assign stop_det = stable[1] && prev[1] && stable[0] && !prev[0];
endmodule : pmbs_pin_sync

// ==== logic/pmbs_status_bank.sv ====
`timescale 1ns/1ps
module pmbs_status_bank (
  input wire logic clk,
  input wire logic rst,
  pmbs_stat_if.bank sif,
  input wire logic [7:0] input_set,
  input wire logic [7:0] temp_set,
  input wire logic bus_err,
  input wire logic sync_lost,
  input wire logic [11:0] mon_v,
  input wire logic [11:0] uv_lim,
  input wire logic [11:0] ov_lim,
  input wire logic out_any,
  input wire logic clear,
  output logic [15:0] summary
);
  logic [7:0] in_reg;
  logic [7:0] tmp_reg;
  logic [7:0] cml_reg;
  logic [7:0] ven_reg;
  logic [7:0] rdata;
  logic [15:0] sum_reg;
  logic [7:0] next_in;
  logic [7:0] next_tmp;
  logic [7:0] next_cml;
  logic [7:0] next_ven;
  logic [7:0] next_rdata;
  logic [15:0] next_sum;
  logic [7:0] cml_set;
  logic [7:0] ven_set;

  function automatic logic [15:0] scaled(input logic [11:0] x, input logic [15:0] k);
    return 16'({4'h0, x} * k);
  endfunction : scaled

  // set wins over clear; reads never clear
  function automatic logic [7:0] latch(input logic [7:0] cur, input logic [7:0] set,
    input logic [7:0] mask, input logic clr);
    return (set | (clr ? 8'h00 : cur)) & mask;
  endfunction : latch

  always_comb begin
    cml_set = 8'h00;
    cml_set[pmbs_pkg::CML_BAD_CMD_BIT] = sif.ev_bad_cmd;
    cml_set[pmbs_pkg::CML_BAD_DATA_BIT] = sif.ev_bad_data;
    cml_set[pmbs_pkg::CML_PEC_BIT] = sif.ev_pec;
    cml_set[pmbs_pkg::CML_OTHER_BIT] = sif.ev_other;
    ven_set = 8'h00;
    ven_set[pmbs_pkg::VEN_BUS_BIT] = bus_err;
    ven_set[pmbs_pkg::VEN_UV_WARN_BIT] =
      scaled(mon_v, pmbs_pkg::MON_SCALE) < scaled(uv_lim, pmbs_pkg::MON_UV_WARN_SCALE);
    ven_set[pmbs_pkg::VEN_OV_WARN_BIT] =
      scaled(mon_v, pmbs_pkg::MON_SCALE) > scaled(ov_lim, pmbs_pkg::MON_OV_WARN_SCALE);
    ven_set[pmbs_pkg::VEN_SYNC_BIT] = sync_lost;
    ven_set[pmbs_pkg::VEN_UV_FAULT_BIT] = mon_v < uv_lim;
    ven_set[pmbs_pkg::VEN_OV_FAULT_BIT] = mon_v > ov_lim;
    next_in = latch(in_reg, input_set, pmbs_pkg::INPUT_MASK, clear);
    next_tmp = latch(tmp_reg, temp_set, pmbs_pkg::TEMP_MASK, clear);
    next_cml = latch(cml_reg, cml_set, pmbs_pkg::CML_MASK, clear);
    next_ven = latch(ven_reg, ven_set, pmbs_pkg::VENDOR_MASK, clear);
    case (sif.cmd)
      pmbs_pkg::CMD_INPUT: next_rdata = in_reg;
      pmbs_pkg::CMD_TEMP: next_rdata = tmp_reg;
      pmbs_pkg::CMD_CML: next_rdata = cml_reg;
      pmbs_pkg::CMD_VENDOR: next_rdata = ven_reg;
      default: next_rdata = pmbs_pkg::IDLE_BYTE;
    endcase
    next_sum = 16'h0000;
    next_sum[pmbs_pkg::SUM_INPUT_BIT] = |in_reg;
    next_sum[pmbs_pkg::SUM_VENDOR_BIT] = |ven_reg;
    next_sum[pmbs_pkg::SUM_OTHER_BIT] = out_any || (|{in_reg, tmp_reg, cml_reg, ven_reg});
    next_sum[pmbs_pkg::SUM_TEMP_BIT] = |tmp_reg;
    next_sum[pmbs_pkg::SUM_CML_BIT] = |cml_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_reg <= pmbs_pkg::STATUS_RESET;
      tmp_reg <= pmbs_pkg::STATUS_RESET;
      cml_reg <= pmbs_pkg::STATUS_RESET;
      ven_reg <= pmbs_pkg::STATUS_RESET;
      rdata <= pmbs_pkg::STATUS_RESET;
      sum_reg <= 16'h0000;
    end else begin
      in_reg <= next_in;
      tmp_reg <= next_tmp;
      cml_reg <= next_cml;
      ven_reg <= next_ven;
      rdata <= next_rdata;
      sum_reg <= next_sum;
    end
  end

  assign sif.rdata = rdata;
  assign summary = sum_reg;
endmodule : pmbs_status_bank

// ==== verification/pmbs_status_registers_properties.sv ====
`timescale 1ns/1ps
module pmbs_status_registers_properties (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SDA_OE_N,
  input wire logic INPUT_OV_FAULT,
  input wire logic INPUT_OV_WARN,
  input wire logic INPUT_UV_WARN,
  input wire logic INPUT_UV_FAULT,
  input wire logic TEMP_OT_FAULT,
  input wire logic TEMP_OT_WARN,
  input wire logic TEMP_UT_WARN,
  input wire logic TEMP_UT_FAULT,
  input wire logic INTERCONNECT_ERR,
  input wire logic EXT_SYNC_LOST,
  input wire logic [11:0] MONITOR_PIN_VOLTAGE,
  input wire logic [11:0] MONITOR_UV_LIMIT,
  input wire logic [11:0] MONITOR_OV_LIMIT,
  input wire logic OUTPUT_STATUS_ANY,
  input wire logic CLEAR_FAULTS,
  input wire logic [15:0] SUMMARY_WORD
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  logic in_any;
  logic tmp_any;
  assign in_any = INPUT_OV_FAULT | INPUT_OV_WARN | INPUT_UV_WARN | INPUT_UV_FAULT;
  assign tmp_any = TEMP_OT_FAULT | TEMP_OT_WARN | TEMP_UT_WARN | TEMP_UT_FAULT;
  // summary lags the latch by one more cycle
  sequence s_temp_seen;
    !CLEAR_FAULTS ##1 SUMMARY_WORD[2];
  endsequence
  a_input_summary: assert property (in_any |-> ##2 SUMMARY_WORD[13] && SUMMARY_WORD[9])
    else $error("input event missing from summary");
  a_temp_summary: assert property (tmp_any |-> ##2 SUMMARY_WORD[2] && SUMMARY_WORD[9])
    else $error("temperature event missing from summary");
  a_vendor_events: assert property ((INTERCONNECT_ERR || EXT_SYNC_LOST)
    |-> ##2 SUMMARY_WORD[12])
    else $error("vendor event missing from summary");
  a_mon_under: assert property (MONITOR_PIN_VOLTAGE < MONITOR_UV_LIMIT
    |-> ##2 SUMMARY_WORD[12])
    else $error("monitor under limit not flagged");
  a_mon_over: assert property (MONITOR_PIN_VOLTAGE > MONITOR_OV_LIMIT
    |-> ##2 SUMMARY_WORD[12])
    else $error("monitor over limit not flagged");
  a_temp_kept: assert property (s_temp_seen |=> SUMMARY_WORD[2])
    else $error("temperature flag lost without clear");
  a_clear_drops: assert property (CLEAR_FAULTS && !tmp_any |-> ##2 !SUMMARY_WORD[2])
    else $error("clear did not drop temperature flag");
  a_unused_zero: assert property ((SUMMARY_WORD & 16'hCDF9) == 16'h0000)
    else $error("unused summary bit set");
  a_other_any: assert property (OUTPUT_STATUS_ANY |-> ##[1:2] SUMMARY_WORD[9])
    else $error("outside status missing from summary");
  a_reset_clean: assert property ($fell(RST) |-> SDA_OE_N && SUMMARY_WORD == 16'h0000)
    else $error("state not clean after reset");
endmodule : pmbs_status_registers_properties
bind pmbs_status_registers pmbs_status_registers_properties chk_u (.REF_CLK, .RST, .SDA_OE_N,
  .INPUT_OV_FAULT, .INPUT_OV_WARN, .INPUT_UV_WARN, .INPUT_UV_FAULT, .TEMP_OT_FAULT,
  .TEMP_OT_WARN, .TEMP_UT_WARN, .TEMP_UT_FAULT, .INTERCONNECT_ERR, .EXT_SYNC_LOST,
  .MONITOR_PIN_VOLTAGE, .MONITOR_UV_LIMIT, .MONITOR_OV_LIMIT, .OUTPUT_STATUS_ANY,
  .CLEAR_FAULTS, .SUMMARY_WORD);

// ==== verification/pmbs_host_model.sv ====
`timescale 1ns/1ps
module pmbs_host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // scl period 80 ns; sda only moves while scl is low
  task automatic clk_bit(input logic b, output logic r);
    sda_drv = b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
    #20;
  endtask : clk_bit
  task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
    output logic nak);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(ak, nak);
  endtask : xfer
  task automatic start;
    sda_drv = 1'b1;
    #20 scl = 1'b1;
    #20 sda_drv = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask : start
  task automatic stop;
    sda_drv = 1'b0;
    #20 scl = 1'b1;
    #20 sda_drv = 1'b1;
    #40;
  endtask : stop
  // read byte; host nacks the data byte to end early
  task automatic read_reg(input logic [6:0] adr, input logic [7:0] cmd, output logic [7:0] d,
    output logic nak);
    logic [7:0] rx;
    logic a;
    start();
    xfer({adr, 1'b0}, 1'b1, rx, nak);
    xfer(cmd, 1'b1, rx, a);
    start();
    xfer({adr, 1'b1}, 1'b1, rx, a);
    xfer(8'hFF, 1'b1, d, a);
    stop();
  endtask : read_reg
  // n data bytes, high byte first; rs adds a repeated start before the stop
  task automatic write_reg(input logic [7:0] cmd, input logic [15:0] dat, input int n,
    input logic rs);
    logic [7:0] rx;
    logic a;
    start();
    xfer({pmbs_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, a);
    xfer(cmd, 1'b1, rx, a);
    if (n > 0) xfer(dat[15:8], 1'b1, rx, a);
    if (n > 1) xfer(dat[7:0], 1'b1, rx, a);
    if (rs) start();
    stop();
  endtask : write_reg
endmodule : pmbs_host_model

// ==== verification/tb_pmbus_status_registers.sv ====
`timescale 1ns/1ps
module tb_pmbus_status_registers;
  logic ref_clk;
  logic rst;
  logic scl;
  logic sda_drv;
  logic sda_oe_n;
  logic sda_out;
  logic sda;
  logic [9:0] ev;
  logic [11:0] mon_v;
  logic out_any;
  logic clr;
  logic [15:0] summary;
  logic [7:0] d;
  logic nak;
  int fail_count;
  int total_checks;
  // open drain: pull-up unless someone pulls low
  assign sda = sda_drv & (sda_oe_n | sda_out);
  pmbs_host_model host_u (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  pmbs_status_registers dut_u (.REF_CLK(ref_clk), .RST(rst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .INPUT_OV_FAULT(ev[9]), .INPUT_OV_WARN(ev[8]),
    .INPUT_UV_WARN(ev[7]), .INPUT_UV_FAULT(ev[6]), .TEMP_OT_FAULT(ev[5]), .TEMP_OT_WARN(ev[4]),
    .TEMP_UT_WARN(ev[3]), .TEMP_UT_FAULT(ev[2]), .INTERCONNECT_ERR(ev[1]),
    .EXT_SYNC_LOST(ev[0]), .MONITOR_PIN_VOLTAGE(mon_v), .MONITOR_UV_LIMIT(12'h032),
    .MONITOR_OV_LIMIT(12'h0C8), .OUTPUT_STATUS_ANY(out_any), .CLEAR_FAULTS(clr),
    .SUMMARY_WORD(summary));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic clear_all;
    @(negedge ref_clk) clr = 1'b1;
    @(negedge ref_clk) clr = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("summary after clear", summary, 16'h0000);
  endtask : clear_all
  task automatic rd(input logic [7:0] cmd);
    host_u.read_reg(pmbs_pkg::DEV_ADDR_DEFAULT, cmd, d, nak);
  endtask : rd
  task automatic t_reset_values;
    logic [7:0] cmds [4] = '{8'h7C, 8'h7D, 8'h7E, 8'h80};
    foreach (cmds[i]) begin
      rd(cmds[i]);
      check("reset value", {8'h00, d}, 16'h0000);
    end
  endtask : t_reset_values
  // one event at a time; read twice to show reads keep bits
  task automatic t_events;
    logic [7:0] cmd;
    logic [7:0] exp;
    logic [15:0] sum;
    for (int i = 9; i >= 0; i--) begin
      cmd = i > 5 ? 8'h7C : (i > 1 ? 8'h7D : 8'h80);
      exp = i > 5 ? 8'h80 >> (9 - i) : (i > 1 ? 8'h80 >> (5 - i) : (i ? 8'h40 : 8'h08));
      sum = i > 5 ? 16'h2200 : (i > 1 ? 16'h0204 : 16'h1200);
      @(negedge ref_clk) ev = 10'h001 << i;
      @(negedge ref_clk) ev = 10'h000;
      @(negedge ref_clk);
      check("summary", summary, sum);
      repeat (2) begin
        rd(cmd);
        check("status byte", {8'h00, d}, {8'h00, exp});
      end
      clear_all();
    end
  endtask : t_events
  // boundaries of the 10 percent margins, limits 50 and 200
  task automatic t_monitor;
    logic [11:0] v [4] = '{12'd44, 12'd45, 12'd220, 12'd221};
    logic [7:0] e [4] = '{8'h22, 8'h02, 8'h01, 8'h11};
    foreach (v[i]) begin
      @(negedge ref_clk) mon_v = v[i];
      @(negedge ref_clk) mon_v = 12'd100;
      rd(8'h80);
      check("monitor status", {8'h00, d}, {8'h00, e[i]});
      clear_all();
    end
  endtask : t_monitor
  task automatic t_comms;
    rd(8'h7F);
    check("unsupported read", {8'h00, d}, 16'h00FF);
    rd(8'h7E);
    check("bad command flag", {8'h00, d}, 16'h0080);
    check("summary comms", summary, 16'h0202);
    clear_all();
    host_u.write_reg(8'h7C, 16'h5A00, 1, 1'b0);
    rd(8'h7E);
    check("read-only write flag", {8'h00, d}, 16'h0002);
    clear_all();
    // wrong packet error code on a two-byte write
    host_u.write_reg(8'h80, 16'hA500, 2, 1'b0);
    rd(8'h7E);
    check("packet error flag", {8'h00, d}, 16'h0022);
    clear_all();
    host_u.write_reg(8'h7D, 16'h3C00, 1, 1'b1);
    rd(8'h7E);
    check("bad data flag", {8'h00, d & 8'h40}, 16'h0040);
    clear_all();
  endtask : t_comms
  task automatic t_other;
    host_u.read_reg(7'h41, 8'h7C, d, nak);
    check("foreign address nak", {15'h0000, nak}, 16'h0001);
    @(negedge ref_clk) out_any = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("outside status", summary, 16'h0200);
    out_any = 1'b0;
  endtask : t_other
  initial begin
    fail_count = 0;
    total_checks = 0;
    rst = 1'b1;
    ev = 10'h000;
    mon_v = 12'd100;
    out_any = 1'b0;
    clr = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_reset_values();
    t_events();
    t_monitor();
    t_comms();
    t_other();
    conclude();
  end
  // cuts a hang short
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    conclude();
  end
endmodule : tb_pmbus_status_registers
